// ===== hdl/tc_ctrl.sv
// Timer control, event routing and interrupt enables behind an APB slave.
//
// Functional notes
// - Direction reads 0 up, 1 down; set-register one selects down.
// - Channel mode bits 5:4: one makes capture, zero makes compare.
// - Output invert bits 1:0 flip the matching waveform output.
// - Capture/invert register is write-protected and crosses to tick domain.
// - Reserved bits read zero; software writes them zero.
// - Debug-run one keeps counting in debug halt; zero halts it.
// - Debug-run bit survives software reset; all else resets.
// - Channel event enables 13:12 emit an event per match or capture.
// - Wrap event enable bit 8 emits an event per wrap.
// - Event register protected; only action field locked while enabled.
// - Input enable bit 5 gates incoming events.
// - Input invert bit 4 inverts event for period and width capture.
// - Action 0 off, 1 retrigger, 2 count per event, 3 start.
// - Action 5: period ch0, width ch1; action 6 swaps them.
// - Enable-clear writes of one clear enables; reads show state.
// - Enable set and clear share one set of enable bits.
// - Channel flag set one tick after hit; capture read clears it.
// - Capture onto a channel with flag still set raises error flag.
`timescale 1ns/10ps
module tc_ctrl
#(
   parameter int CNT_W    = tc_ctrl_pkg::CNT_W,
   parameter int PRESCALE = tc_ctrl_pkg::PRESCALE_DIV
)
(
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [tc_ctrl_pkg::APB_AW-1:0] paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic                          debug_halt,
   input  wire logic                          write_protect,
   input  wire logic                          event_in,
   output logic      [1:0]                    waveform_output_pin,
   output logic      [1:0]                    channel_event_out,
   output logic                               wrap_event_out
);
   import tc_ctrl_pkg::*;

   localparam logic [CNT_W-1:0] CNT_MAX = '1;
   localparam int PW = $clog2(PRESCALE + 1);
   localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);

   logic [2:0]       sync_s;
   logic             halt_s;
   logic             wp_s;
   logic             evin_s;
   logic             evin_prev_q;
   logic [7:0]       idx;
   logic             access;
   logic             wr_go;
   logic             rd_go;
   logic             srst;
   logic [31:0]      rd_d;
   logic             enable_q;
   logic             dir_q;
   logic [7:0]       capinv_q;
   logic [7:0]       capinv_new_q;
   logic             busy_q;
   logic             run_during_debug_halt_q;
   logic [15:0]      evt_q;
   logic [7:0]       ien_q;
   logic [7:0]       flags_q;
   logic [7:0]       flag_set;
   logic [7:0]       flag_clr;
   logic [1:0]       pend_q;
   logic [PW-1:0]    pre_q;
   logic             tick;
   logic             halted;
   logic             step;
   run_state_type    run_q;
   logic             running;
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] cc_q [2];
   event_action_type act;
   logic             ev_ok;
   logic             meas;
   logic             m_now;
   logic             m_prev;
   logic             m_rise;
   logic             m_fall;
   logic             cnt_step;
   logic             wrap_hit;
   logic [1:0]       cap_ev;
   logic [1:0]       cap_sel;
   logic [1:0]       full;
   logic [1:0]       ch_hit;

   function automatic logic hit(input logic go, input logic [7:0] i,
                                input logic [7:0] k);
      return go && (i == k);
   endfunction

   function automatic logic mapped(input logic [7:0] i);
      return i inside {IDX_CTRLA, IDX_DIR_CLR, IDX_DIR_SET, IDX_CAPINV,
                       IDX_DBG, IDX_EVT, IDX_IEN_CLR, IDX_IEN_SET,
                       IDX_FLAG, IDX_STATUS, IDX_COUNT, IDX_CH0, IDX_CH1};
   endfunction

   tc_sync2 #(.W(3)) u_sync
   (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({debug_halt, write_protect, event_in}),
      .q     (sync_s)
   );

   assign halt_s = sync_s[2];
   assign wp_s   = sync_s[1];
   assign evin_s = sync_s[0];

   // Bus side: one wait state, then the answer from registers.
   assign idx    = paddr[9:2];
   assign access = psel && penable;
   assign wr_go  = access && pready && pwrite && !pslverr;
   assign rd_go  = access && pready && !pwrite && !pslverr;
   assign srst   = hit(wr_go && !wp_s, idx, IDX_CTRLA) && pwdata[SWRST_BIT];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end
      else
      begin
         pready  <= access && !pready;
         pslverr <= access && !pready &&
                    !(mapped(idx) && paddr[11:10] == 2'h0 &&
                      paddr[1:0] == 2'h0);
         prdata  <= (access && !pready && !pwrite) ? rd_d : 32'h0;
      end
   end

   // Reserved bits come back as zero.
   always_comb
   begin
      rd_d = 32'h0;
      unique case (idx)
         IDX_CTRLA:   rd_d[ENABLE_BIT] = enable_q;
         IDX_DIR_CLR,
         IDX_DIR_SET: rd_d[DIR_BIT] = dir_q;
         IDX_CAPINV:  rd_d[7:0] = capinv_q & CAPINV_MASK;
         IDX_DBG:     rd_d[0] = run_during_debug_halt_q;
         IDX_EVT:     rd_d[15:0] = evt_q & EVT_MASK;
         IDX_IEN_CLR,
         IDX_IEN_SET: rd_d[7:0] = ien_q;
         IDX_FLAG:    rd_d[7:0] = flags_q;
         IDX_STATUS:
         begin
            rd_d[ST_BUSY_BIT] = busy_q;
            rd_d[ST_STOP_BIT] = !running;
         end
         IDX_COUNT:   rd_d[CNT_W-1:0] = count_q;
         IDX_CH0:     rd_d[CNT_W-1:0] = cc_q[0];
         IDX_CH1:     rd_d[CNT_W-1:0] = cc_q[1];
         default:     rd_d = 32'h0;
      endcase
   end

   // Control registers; software reset spares the debug-run bit.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         enable_q <= 1'b0;
         dir_q    <= 1'b0;
         evt_q    <= EVT_RST;
         ien_q    <= IEN_RST;
      end
      else if (srst)
      begin
         enable_q <= 1'b0;
         dir_q    <= 1'b0;
         evt_q    <= EVT_RST;
         ien_q    <= IEN_RST;
      end
      else if (!wp_s)
      begin
         if (hit(wr_go, idx, IDX_CTRLA))
            enable_q <= pwdata[ENABLE_BIT];
         if (hit(wr_go, idx, IDX_DIR_SET) && pwdata[DIR_BIT])
            dir_q <= 1'b1;
         if (hit(wr_go, idx, IDX_DIR_CLR) && pwdata[DIR_BIT])
            dir_q <= 1'b0;
         if (hit(wr_go, idx, IDX_EVT))
         begin
            evt_q[15:3] <= pwdata[15:3] & EVT_MASK[15:3];
            if (!enable_q)
               evt_q[2:0] <= pwdata[2:0];
         end
         if (hit(wr_go, idx, IDX_IEN_SET))
            ien_q <= ien_q | (pwdata[7:0] & IEN_MASK);
         if (hit(wr_go, idx, IDX_IEN_CLR))
            ien_q <= ien_q & ~(pwdata[7:0] & IEN_MASK);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         run_during_debug_halt_q <= 1'b0;
      else if (hit(wr_go && !wp_s, idx, IDX_DBG) && !srst)
         run_during_debug_halt_q <= pwdata[0];
   end

   // Capture/invert setting is applied on the next counter tick.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         capinv_q     <= CAPINV_RST;
         capinv_new_q <= CAPINV_RST;
         busy_q       <= 1'b0;
      end
      else if (srst)
      begin
         capinv_q     <= CAPINV_RST;
         capinv_new_q <= CAPINV_RST;
         busy_q       <= 1'b0;
      end
      else if (hit(wr_go && !wp_s, idx, IDX_CAPINV))
      begin
         capinv_new_q <= pwdata[7:0] & CAPINV_MASK;
         busy_q       <= 1'b1;
      end
      else if (busy_q && tick)
      begin
         capinv_q <= capinv_new_q;
         busy_q   <= 1'b0;
      end
   end

   // Prescaler making the counter tick.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pre_q <= '0;
      else
         pre_q <= (pre_q == PRE_LAST) ? '0 : pre_q + PW'(1);
   end

   assign tick     = pre_q == PRE_LAST;
   assign halted   = halt_s && !run_during_debug_halt_q;
   assign step     = tick && !halted;
   assign running  = run_q == RUN_ACTIVE && enable_q;
   assign act      = event_action_type'(evt_q[2:0]);
   assign ev_ok    = evt_q[IN_EN_BIT] && evin_s && !evin_prev_q &&
                     !halted;
   assign meas     = (act == ACT_PER_WID || act == ACT_WID_PER) &&
                     evt_q[IN_EN_BIT] && running && !halted;
   assign m_now    = evin_s ^ evt_q[IN_POL_BIT];
   assign m_prev   = evin_prev_q ^ evt_q[IN_POL_BIT];
   assign m_rise   = meas && m_now && !m_prev;
   assign m_fall   = meas && !m_now && m_prev;
   assign cnt_step = running && !halted &&
                     ((act == ACT_COUNT) ? ev_ok : tick);
   assign wrap_hit = cnt_step &&
                     (dir_q ? count_q == '0 : count_q == CNT_MAX);
   assign cap_ev   = (act == ACT_PER_WID) ? {m_fall, m_rise}
                                          : {m_rise, m_fall};
   assign cap_sel  = capinv_q[CAP_SEL_LSB +: 2];
   assign full     = flags_q[FLG_CH_LSB +: 2] | pend_q;

   always_comb
   begin
      for (int c = 0; c < 2; c++)
      begin
         if (cap_sel[c])
            ch_hit[c] = cap_ev[c] && !full[c];
         else
            ch_hit[c] = cnt_step && count_q == cc_q[c];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         evin_prev_q <= 1'b0;
      else
         evin_prev_q <= evin_s;
   end

   // Run state follows enable and start-type event actions.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         run_q <= RUN_STOPPED;
      else if (srst)
         run_q <= RUN_STOPPED;
      else if (hit(wr_go && !wp_s, idx, IDX_CTRLA) && !enable_q &&
               pwdata[ENABLE_BIT])
         run_q <= RUN_ACTIVE;
      else if (!enable_q)
         run_q <= RUN_STOPPED;
      else if (ev_ok && (act == ACT_RETRIG || act == ACT_START))
         run_q <= RUN_ACTIVE;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_q <= '0;
      else if (srst)
         count_q <= '0;
      else if (ev_ok && act == ACT_RETRIG)
         count_q <= dir_q ? CNT_MAX : '0;
      else if (m_rise)
         count_q <= '0;
      else if (wrap_hit)
         count_q <= dir_q ? CNT_MAX : '0;
      else if (cnt_step)
         count_q <= dir_q ? count_q - 1'b1 : count_q + 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cc_q[0] <= '0;
         cc_q[1] <= '0;
      end
      else if (srst)
      begin
         cc_q[0] <= '0;
         cc_q[1] <= '0;
      end
      else
      begin
         for (int c = 0; c < 2; c++)
         begin
            if (cap_sel[c] && ch_hit[c])
               cc_q[c] <= count_q;
            else if (!cap_sel[c] && !wp_s &&
                     hit(wr_go, idx, c == 0 ? IDX_CH0 : IDX_CH1))
               cc_q[c] <= pwdata[CNT_W-1:0];
         end
      end
   end

   // Hits wait one tick in pend_q before reaching the flags.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pend_q <= 2'h0;
      else if (srst)
         pend_q <= 2'h0;
      else if (step)
         pend_q <= ch_hit;
      else
         pend_q <= pend_q | ch_hit;
   end

   always_comb
   begin
      flag_set = 8'h0;
      flag_clr = 8'h0;
      if (step)
         flag_set[FLG_CH_LSB +: 2] = pend_q;
      flag_set[FLG_WRAP_BIT] = wrap_hit;
      flag_set[FLG_ERR_BIT]  = |(cap_ev & cap_sel & full);
      flag_set[FLG_SYNC_BIT] = busy_q && tick;
      if (hit(wr_go, idx, IDX_FLAG))
         flag_clr = pwdata[7:0] & IEN_MASK;
      if (hit(rd_go, idx, IDX_CH0) && cap_sel[0])
         flag_clr[FLG_CH_LSB] = 1'b1;
      if (hit(rd_go, idx, IDX_CH1) && cap_sel[1])
         flag_clr[FLG_CH_LSB + 1] = 1'b1;
   end

   // A set in the same cycle as a clear wins.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flags_q <= 8'h0;
      else if (srst)
         flags_q <= 8'h0;
      else
         flags_q <= (flags_q & ~flag_clr) | flag_set;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         waveform_output_pin <= 2'h0;
         channel_event_out   <= 2'h0;
         wrap_event_out      <= 1'b0;
      end
      else
      begin
         for (int c = 0; c < 2; c++)
            waveform_output_pin[c] <= (count_q < cc_q[c]) ^
                                      capinv_q[POL_LSB + c];
         channel_event_out <= ch_hit & evt_q[CH_EVT_LSB +: 2];
         wrap_event_out    <= wrap_hit && evt_q[WRAP_EVT_BIT];
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   dir_set_a: assert property (
      hit(wr_go && !wp_s, idx, IDX_DIR_SET) && pwdata[0] && !srst
      |=> dir_q) else $error("direction set write did not count down");

   wave_pol_a: assert property (
      ##1 waveform_output_pin[0] ==
      ($past(count_q < cc_q[0]) ^ $past(capinv_q[0])))
      else $error("waveform output ignores the invert bit");

   capinv_sync_a: assert property (
      hit(wr_go && !wp_s, idx, IDX_CAPINV) && !srst
      |=> busy_q && $stable(capinv_q))
      else $error("capture invert setting applied without crossing");

   halt_hold_a: assert property (
      halted && !srst |=> $stable(count_q) && !wrap_event_out)
      else $error("counter moved during debug halt");

   dbg_keep_a: assert property (
      srst |=> $stable(run_during_debug_halt_q))
      else $error("debug run bit lost on software reset");

   wrap_evt_a: assert property (
      wrap_hit |=> wrap_event_out == $past(evt_q[WRAP_EVT_BIT]))
      else $error("wrap event does not follow its enable");

   act_lock_a: assert property (
      enable_q && !srst && hit(wr_go, idx, IDX_EVT)
      |=> $stable(evt_q[2:0]))
      else $error("event action changed while enabled");

   ien_clr_a: assert property (
      hit(wr_go && !wp_s, idx, IDX_IEN_CLR) && pwdata[0]
      |=> !ien_q[0] ##1 !ien_q[0] || $past(hit(wr_go, idx, IDX_IEN_SET)))
      else $error("enable clear write left the enable set");

   err_flag_a: assert property (
      |(cap_ev & cap_sel & full) && !srst |=> flags_q[FLG_ERR_BIT])
      else $error("capture overrun did not raise the error flag");
endmodule

// ===== hdl/tc_ctrl_pkg.sv
// Register map, field layout and encodings of the timer control block.
package tc_ctrl_pkg;
   localparam int APB_AW = 12;
   localparam int CNT_W = 16;
   localparam int PRESCALE_DIV = 4;
   localparam logic [7:0] IDX_CTRLA = 8'h00;
   localparam logic [7:0] IDX_DIR_CLR = 8'h04;
   localparam logic [7:0] IDX_DIR_SET = 8'h05;
   localparam logic [7:0] IDX_CAPINV = 8'h06;
   localparam logic [7:0] IDX_DBG = 8'h08;
   localparam logic [7:0] IDX_EVT = 8'h0a;
   localparam logic [7:0] IDX_IEN_CLR = 8'h0c;
   localparam logic [7:0] IDX_IEN_SET = 8'h0d;
   localparam logic [7:0] IDX_FLAG = 8'h0e;
   localparam logic [7:0] IDX_STATUS = 8'h0f;
   localparam logic [7:0] IDX_COUNT = 8'h10;
   localparam logic [7:0] IDX_CH0 = 8'h18;
   localparam logic [7:0] IDX_CH1 = 8'h1a;
   localparam logic [7:0] CAPINV_MASK = 8'h33;
   localparam logic [15:0] EVT_MASK = 16'h3137;
   localparam logic [7:0] IEN_MASK = 8'h3b;
   localparam logic [7:0] CAPINV_RST = 8'h00;
   localparam logic [15:0] EVT_RST = 16'h0000;
   localparam logic [7:0] IEN_RST = 8'h00;
   localparam int SWRST_BIT = 0;
   localparam int ENABLE_BIT = 1;
   localparam int DIR_BIT = 0;
   localparam int CAP_SEL_LSB = 4;
   localparam int POL_LSB = 0;
   localparam int CH_EVT_LSB = 12;
   localparam int WRAP_EVT_BIT = 8;
   localparam int IN_EN_BIT = 5;
   localparam int IN_POL_BIT = 4;
   localparam int FLG_CH_LSB = 4;
   localparam int FLG_SYNC_BIT = 3;
   localparam int FLG_ERR_BIT = 1;
   localparam int FLG_WRAP_BIT = 0;
   localparam int ST_BUSY_BIT = 7;
   localparam int ST_STOP_BIT = 3;
   typedef enum logic [2:0]
   {
      ACT_OFF     = 3'h0,
      ACT_RETRIG  = 3'h1,
      ACT_COUNT   = 3'h2,
      ACT_START   = 3'h3,
      ACT_PER_WID = 3'h5,
      ACT_WID_PER = 3'h6
   } event_action_type;
   typedef enum logic [1:0]
   {
      RUN_STOPPED = 2'b01,
      RUN_ACTIVE  = 2'b10
   } run_state_type;
endpackage

// ===== hdl/tc_sync2.sv
// Two flip-flop synchroniser for asynchronous level inputs.
`timescale 1ns/10ps
module tc_sync2 #(parameter int W = 1)
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         q      <= '0;
      end
      else
      begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

// ===== tb/tb.sv
// Self-checking testbench for the timer control block.
`timescale 1ns/10ps
module tb;
   import tc_ctrl_pkg::*;
   logic              pclk;
   logic              presetn;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [APB_AW-1:0] paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              debug_halt;
   logic              write_protect;
   logic              event_in;
   logic [1:0]        wave;
   logic [1:0]        ch_evt;
   logic              wrap_evt;
   logic [2:0]        evts;
   logic [31:0]       rd;
   logic [31:0]       rd2;
   logic              err;
   logic              hit;
   int                error_cnt;
   int                n_tests;

   assign evts = {wrap_evt, ch_evt};

   tc_ctrl #(.CNT_W(8), .PRESCALE(2)) i_dut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .debug_halt(debug_halt),
      .write_protect(write_protect), .event_in(event_in),
      .waveform_output_pin(wave), .channel_event_out(ch_evt),
      .wrap_event_out(wrap_evt)
   );

   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task automatic complete_run;
      $display("mismatches %0d comparisons %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // One APB transfer; read data is taken at the edge that sees pready.
   task automatic apb(input logic wr, input logic [7:0] idx,
                      input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         error_cnt++;
         complete_run();
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
      apb(1'b1, idx, wd);
   endtask

   task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      check(rd, exp);
   endtask

   task automatic sync_wait;
      int n;
      n = 0;
      do
      begin
         apb(1'b0, IDX_STATUS, 32'h0);
         n++;
      end
      while (rd[ST_BUSY_BIT] !== 1'b0 && n < 10);
      if (rd[ST_BUSY_BIT] !== 1'b0)
      begin
         error_cnt++;
         complete_run();
      end
   endtask

   task automatic watch(input int sel, input int n);
      hit = 1'b0;
      repeat (n)
      begin
         @(posedge pclk);
         if (evts[sel] === 1'b1)
            hit = 1'b1;
      end
   endtask

   task automatic pulses(input int n);
      repeat (n)
      begin
         event_in <= 1'b1;
         cyc(4);
         event_in <= 1'b0;
         cyc(8);
      end
   endtask

   task automatic t_regs;
      rdc(IDX_CAPINV, 32'h0);
      rdc(IDX_DBG, 32'h0);
      rdc(IDX_EVT, 32'h0);
      rdc(IDX_IEN_CLR, 32'h0);
      wr(IDX_CAPINV, 32'h33);
      sync_wait();
      rdc(IDX_CAPINV, 32'h33);
      wr(IDX_DBG, 32'h1);
      rdc(IDX_DBG, 32'h1);
      wr(IDX_EVT, 32'h3137);
      rdc(IDX_EVT, 32'h3137);
      apb(1'b0, 8'h01, 32'h0);
      check({31'b0, err}, 32'h1);
      wr(IDX_CAPINV, 32'h0);
      wr(IDX_DBG, 32'h0);
      wr(IDX_EVT, 32'h0);
      sync_wait();
   endtask

   task automatic t_dir_ien;
      rdc(IDX_DIR_SET, 32'h0);
      wr(IDX_DIR_SET, 32'h1);
      sync_wait();
      rdc(IDX_DIR_CLR, 32'h1);
      wr(IDX_DIR_SET, 32'h0);
      rdc(IDX_DIR_SET, 32'h1);
      wr(IDX_DIR_CLR, 32'h1);
      sync_wait();
      rdc(IDX_DIR_SET, 32'h0);
      wr(IDX_IEN_SET, 32'h3b);
      rdc(IDX_IEN_CLR, 32'h3b);
      wr(IDX_IEN_CLR, 32'h0);
      rdc(IDX_IEN_SET, 32'h3b);
      wr(IDX_IEN_CLR, 32'h09);
      rdc(IDX_IEN_SET, 32'h32);
      wr(IDX_IEN_CLR, 32'h32);
      rdc(IDX_IEN_CLR, 32'h0);
   endtask

   task automatic t_protect_wave;
      write_protect <= 1'b1;
      cyc(3);
      wr(IDX_CAPINV, 32'h03);
      wr(IDX_DBG, 32'h01);
      cyc(4);
      rdc(IDX_CAPINV, 32'h0);
      rdc(IDX_DBG, 32'h0);
      write_protect <= 1'b0;
      cyc(3);
      wr(IDX_CH0, 32'h0);
      wr(IDX_CH1, 32'h0f);
      for (int i = 0; i < 4; i++)
      begin
         wr(IDX_CAPINV, 32'(i));
         sync_wait();
         cyc(2);
         check({30'b0, wave}, {30'b0, 2'b10 ^ 2'(i)});
      end
      wr(IDX_CAPINV, 32'h10);
      sync_wait();
      wr(IDX_CH0, 32'h0f);
      rdc(IDX_CH0, 32'h0);
      wr(IDX_CAPINV, 32'h0);
      sync_wait();
   endtask

   task automatic t_wrap;
      wr(IDX_EVT, 32'h100);
      wr(IDX_CTRLA, 32'h2);
      watch(2, 600);
      check({31'b0, hit}, 32'h1);
      wr(IDX_EVT, 32'h0);
      watch(2, 600);
      check({31'b0, hit}, 32'h0);
      wr(IDX_EVT, 32'h100);
      debug_halt <= 1'b1;
      cyc(3);
      apb(1'b0, IDX_COUNT, 32'h0);
      rd2 = rd;
      watch(2, 600);
      check({31'b0, hit}, 32'h0);
      rdc(IDX_COUNT, rd2);
      wr(IDX_CTRLA, 32'h0);
      wr(IDX_DBG, 32'h1);
      wr(IDX_CTRLA, 32'h2);
      watch(2, 600);
      check({31'b0, hit}, 32'h1);
      debug_halt <= 1'b0;
      wr(IDX_CTRLA, 32'h0);
      wr(IDX_DBG, 32'h0);
   endtask

   task automatic t_match;
      wr(IDX_CH0, 32'h05);
      wr(IDX_EVT, 32'h3000);
      wr(IDX_FLAG, 32'h3b);
      rdc(IDX_FLAG, 32'h0);
      wr(IDX_CTRLA, 32'h2);
      for (int s = 0; s < 2; s++)
      begin
         watch(s, 600);
         check({31'b0, hit}, 32'h1);
      end
      apb(1'b0, IDX_FLAG, 32'h0);
      check({30'b0, rd[FLG_CH_LSB+1:FLG_CH_LSB]}, 32'h3);
      wr(IDX_EVT, 32'h0102);
      rdc(IDX_EVT, 32'h0100);
      watch(0, 600);
      check({31'b0, hit}, 32'h0);
      wr(IDX_CTRLA, 32'h0);
   endtask

   task automatic t_count;
      for (int k = 0; k < 8; k++)
      begin
         if (k != 4 && k != 7)
         begin
            wr(IDX_EVT, 32'(k));
            rdc(IDX_EVT, 32'(k));
         end
      end
      wr(IDX_CTRLA, 32'h1);
      sync_wait();
      wr(IDX_EVT, 32'h0002);
      wr(IDX_CTRLA, 32'h2);
      pulses(3);
      rdc(IDX_COUNT, 32'h0);
      wr(IDX_EVT, 32'h0022);
      pulses(3);
      rdc(IDX_COUNT, 32'h3);
      wr(IDX_CTRLA, 32'h0);
      wr(IDX_EVT, 32'h0021);
      wr(IDX_CTRLA, 32'h2);
      cyc(100);
      pulses(1);
      apb(1'b0, IDX_COUNT, 32'h0);
      check({31'b0, rd[7:0] < 8'h10}, 32'h1);
      wr(IDX_CTRLA, 32'h0);
   endtask

   task automatic t_capture;
      logic [31:0] cfg [3] = '{32'h25, 32'h26, 32'h35};
      logic [31:0] w5;
      logic        ok;
      wr(IDX_CAPINV, 32'h30);
      sync_wait();
      for (int c = 0; c < 3; c++)
      begin
         wr(IDX_EVT, cfg[c]);
         wr(IDX_CTRLA, 32'h2);
         pulses(2);
         wr(IDX_FLAG, 32'h3b);
         pulses(1);
         rdc(IDX_FLAG, 32'h30);
         pulses(1);
         rdc(IDX_FLAG, 32'h32);
         apb(1'b0, IDX_CH0, 32'h0);
         rd2 = rd;
         apb(1'b0, IDX_CH1, 32'h0);
         if (c == 0)
            w5 = rd;
         ok = (c == 0) ? (rd2 > rd) : (c == 1) ? (rd > rd2) : (rd > w5);
         check({31'b0, ok}, 32'h1);
         rdc(IDX_FLAG, 32'h02);
         wr(IDX_CTRLA, 32'h0);
         wr(IDX_FLAG, 32'h3b);
      end
   endtask

   task automatic t_swrst;
      wr(IDX_DBG, 32'h1);
      wr(IDX_EVT, 32'h3100);
      wr(IDX_IEN_SET, 32'h3b);
      wr(IDX_CTRLA, 32'h1);
      sync_wait();
      rdc(IDX_DBG, 32'h1);
      rdc(IDX_EVT, 32'h0);
      rdc(IDX_IEN_SET, 32'h0);
      rdc(IDX_CAPINV, 32'h0);
   endtask

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      debug_halt = 1'b0;
      write_protect = 1'b0;
      event_in = 1'b0;
      cyc(6);
      presetn <= 1'b1;
      t_regs();
      t_dir_ien();
      t_protect_wave();
      t_wrap();
      t_match();
      t_count();
      t_capture();
      t_swrst();
      complete_run();
   end
endmodule
